// >>> shared/dcc_pkg.sv
// dcc_pkg: offsets, field positions, reset values and bus codes of the
// dma channel control block.
// assumes a 32-bit AXI4-Lite register bus and one word per channel.
package dcc_pkg;
  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam int unsigned CTRL_BASE_WORD = 0;         // word index of channel 0 control
  localparam logic [31:0] CTRL_RST       = 32'h0000_0000; // control word after reset

  // ---------------------------------------------------------------
  // dma_channel_control field positions
  // ---------------------------------------------------------------
  localparam int unsigned BUSY_BIT   = 15; // channel_active_flag, read only
  localparam int unsigned DIR_BIT    = 8;  // chain_direction_select
  localparam int unsigned ON_BIT     = 7;  // channel_on
  localparam int unsigned EWO_BIT    = 6;  // events_while_off
  localparam int unsigned PERMIT_BIT = 5;  // chain_permit
  localparam int unsigned AUTO_BIT   = 4;  // auto_reenable
  localparam int unsigned SEEN_BIT   = 2;  // event_seen_flag, read only
  localparam int unsigned PRI_LSB    = 0;  // channel_priority_level low bit
  localparam int unsigned PRI_W      = 2;  // channel_priority_level width

  // ---------------------------------------------------------------
  // AXI response codes
  // ---------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// >>> logic/dcc_arb.sv
// dcc_arb: fixed-priority grant among requesting channels.
// assumes req is already gated by channel_on; pri is packed two bits a channel.
`timescale 1ns/1ns
module dcc_arb #(
  parameter int NUM_CH = 4
) (
  input  wire logic                         clk,   // only the checks use it
  input  wire logic                         rst_n, // only the checks use it
  input  wire logic [NUM_CH-1:0]            req,
  input  wire logic [NUM_CH*dcc_pkg::PRI_W-1:0] pri,
  output logic      [NUM_CH-1:0]            grant
);
  // ---------------------------------------------------------------
  // selection
  // ---------------------------------------------------------------
  logic [dcc_pkg::PRI_W-1:0] best_pri; // level of the current winner
  logic                      found;    // some channel already chosen

  // highest level wins; on a tie the lower index keeps it (strict >)
  always_comb begin
    grant    = '0;
    best_pri = '0;
    found    = 1'b0;
    for (int i = 0; i < NUM_CH; i++) begin
      if (req[i] && (!found || pri[i*dcc_pkg::PRI_W +: dcc_pkg::PRI_W] > best_pri)) begin
        grant    = '0;
        grant[i] = 1'b1;
        best_pri = pri[i*dcc_pkg::PRI_W +: dcc_pkg::PRI_W];
        found    = 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  for (genvar i = 0; i < NUM_CH; i++) begin : g_chk
    for (genvar j = 0; j < NUM_CH; j++) begin : g_pair
      property p_no_higher;
        @(posedge clk) disable iff (!rst_n)
        grant[i] |-> !(req[j] && pri[j*2 +: 2] > pri[i*2 +: 2]);
      endproperty
      a_no_higher: assert property (p_no_higher) else $error("grant passed over a higher level");
    end
  end

  property p_some_grant;
    @(posedge clk) disable iff (!rst_n)
    (|req) |-> $onehot(grant);
  endproperty
  a_some_grant: assert property (p_some_grant) else $error("requests pending but no single grant");
endmodule // dcc_arb

// >>> logic/dcc_top.sv
// dcc_top: per-channel control and status of a multi-channel dma engine,
// reached over AXI4-Lite, one control word per channel.
// assumes the transfer engine supplies block-done pulses and busy levels,
// and that all inputs are synchronous to REF_CLK.
// Functional notes
// - bit 15 shows channel active or enabled
// - bit 8 picks which neighbour's completion chains
// - direction bit ignored unless chain permitted
// - bit 7 switches channel on or off
// - bit 6 keeps events while channel off
// - chaining enables only with chain permit set
// - bit 4 keeps channel on after block
// - bit 2 flags a detected event
// - bits 1:0 give priority, 3 highest
// - busy stays until current transaction ends
// - upper half reads zero, writes ignored
// - bits 14 to 9 read zero
//
// The register addresses and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/1ns
module dcc_top #(
  parameter int NUM_CH = 4, // channel count, two or more
  parameter int AW     = 8  // byte address width
) (
  input  wire logic              REF_CLK,
  input  wire logic              RESETN,
  input  wire logic [AW-1:0]     S_AXI_AWADDR,
  input  wire logic              S_AXI_AWVALID,
  output logic                   S_AXI_AWREADY,
  input  wire logic [31:0]       S_AXI_WDATA,
  input  wire logic [3:0]        S_AXI_WSTRB,
  input  wire logic              S_AXI_WVALID,
  output logic                   S_AXI_WREADY,
  output logic [1:0]             S_AXI_BRESP,
  output logic                   S_AXI_BVALID,
  input  wire logic              S_AXI_BREADY,
  input  wire logic [AW-1:0]     S_AXI_ARADDR,
  input  wire logic              S_AXI_ARVALID,
  output logic                   S_AXI_ARREADY,
  output logic [31:0]            S_AXI_RDATA,
  output logic [1:0]             S_AXI_RRESP,
  output logic                   S_AXI_RVALID,
  input  wire logic              S_AXI_RREADY,
  input  wire logic [NUM_CH-1:0] CH_START_EVT,  // start event pulses
  input  wire logic [NUM_CH-1:0] CH_ABORT_EVT,  // abort event pulses
  input  wire logic [NUM_CH-1:0] CH_BLOCK_DONE, // block complete pulses
  input  wire logic [NUM_CH-1:0] CH_XFER_ACTIVE,// transaction in flight
  input  wire logic [NUM_CH-1:0] CH_REQ,        // transfer request pending
  output logic [NUM_CH-1:0]      CH_ENABLE,     // channel_on per channel
  output logic [NUM_CH-1:0]      CH_RUN,        // enabled and event seen
  output logic [NUM_CH-1:0]      CH_ABORT,      // accepted abort, one cycle
  output logic [NUM_CH-1:0]      CH_GRANT,      // one-hot bus grant
  output logic                   CH_GRANT_VALID
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic              awready;  // free to take a write address
    logic              wready;   // free to take write data
    logic              aw_have;  // write address held
    logic              w_have;   // write data held
    logic [AW-1:0]     awaddr;   // held write address
    logic [31:0]       wdata;    // held write data
    logic [3:0]        wstrb;    // held byte strobes
    logic              bvalid;   // write response pending
    logic [1:0]        bresp;
    logic              arready;  // free to take a read address
    logic              rvalid;   // read data pending
    logic [31:0]       rdata;
    logic [1:0]        rresp;
    logic [NUM_CH-1:0] on;       // channel_on
    logic [NUM_CH-1:0] dir;      // chain_direction_select
    logic [NUM_CH-1:0] ewo;      // events_while_off
    logic [NUM_CH-1:0] permit;   // chain_permit
    logic [NUM_CH-1:0] auto_re;  // auto_reenable
    logic [NUM_CH-1:0] seen;     // event_seen_flag
    logic [NUM_CH-1:0] busy;     // channel_active_flag
    logic [NUM_CH-1:0] run;
    logic [NUM_CH-1:0] abort;
    logic [NUM_CH*2-1:0] pri;    // channel_priority_level, two bits each
    logic [NUM_CH-1:0] grant;
    logic              gvalid;
  } dcc_state_s;

  dcc_state_s r;   // registered state
  dcc_state_s nx;  // next state

  localparam logic [AW-3:0] NCH = (AW-2)'(NUM_CH);
  localparam logic [AW-3:0] BASE = (AW-2)'(dcc_pkg::CTRL_BASE_WORD);

  logic              wr_fire;  // held write is applied this cycle
  logic              wr_map;   // held write hits a channel word
  logic [AW-3:0]     wr_idx;   // channel of the held write
  logic              rd_map;   // read address hits a channel word
  logic [AW-3:0]     rd_idx;   // channel of the read
  logic [NUM_CH-1:0] wr_ch;    // write lands on this channel
  logic [NUM_CH-1:0] chain;    // chain trigger per channel
  logic [NUM_CH-1:0] accept;   // event taken per channel
  logic [NUM_CH-1:0] done_up;  // bit i is block done of channel i+1
  logic [NUM_CH-1:0] done_dn;  // bit i is block done of channel i-1
  logic [NUM_CH-1:0] arb_gnt;  // arbiter result

  // ---------------------------------------------------------------
  // control word image of one channel
  // ---------------------------------------------------------------
  // everything not listed stays zero, so unused bits read as zero
  function automatic logic [31:0] ctrl_word(input dcc_state_s s, input int i);
    logic [31:0] w;
    w = dcc_pkg::CTRL_RST;
    w[dcc_pkg::BUSY_BIT]   = s.busy[i];
    w[dcc_pkg::DIR_BIT]    = s.dir[i];
    w[dcc_pkg::ON_BIT]     = s.on[i];
    w[dcc_pkg::EWO_BIT]    = s.ewo[i];
    w[dcc_pkg::PERMIT_BIT] = s.permit[i];
    w[dcc_pkg::AUTO_BIT]   = s.auto_re[i];
    w[dcc_pkg::SEEN_BIT]   = s.seen[i];
    w[dcc_pkg::PRI_LSB +: dcc_pkg::PRI_W] = s.pri[i*2 +: 2];
    return w;
  endfunction

  // neighbour completions, edge channels have no neighbour there
  assign done_up = {1'b0, CH_BLOCK_DONE[NUM_CH-1:1]};
  assign done_dn = {CH_BLOCK_DONE[NUM_CH-2:0], 1'b0};

  // ---------------------------------------------------------------
  // arbiter
  // ---------------------------------------------------------------
  dcc_arb #(
    .NUM_CH (NUM_CH)
  ) u_arb (
    .clk   (REF_CLK),
    .rst_n (RESETN),
    .req   (r.on & CH_REQ),
    .pri   (r.pri),
    .grant (arb_gnt)
  );

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  // address and data are held separately so either may come first;
  // the write is applied only once both are in and no response waits
  always_comb begin
    nx      = r;
    wr_fire = r.aw_have && r.w_have && !r.bvalid;
    wr_idx  = r.awaddr[AW-1:2] - BASE;
    wr_map  = (r.awaddr[1:0] == 2'h0) && (r.awaddr[AW-1:2] >= BASE) && (wr_idx < NCH);
    rd_idx  = S_AXI_ARADDR[AW-1:2] - BASE;
    rd_map  = (S_AXI_ARADDR[1:0] == 2'h0) && (S_AXI_ARADDR[AW-1:2] >= BASE) && (rd_idx < NCH);
    wr_ch   = '0;
    chain   = '0;
    accept  = '0;
    // write address and data capture
    if (S_AXI_AWVALID && r.awready) begin
      nx.awaddr  = S_AXI_AWADDR;
      nx.aw_have = 1'b1;
    end
    if (S_AXI_WVALID && r.wready) begin
      nx.wdata  = S_AXI_WDATA;
      nx.wstrb  = S_AXI_WSTRB;
      nx.w_have = 1'b1;
    end
    // apply and answer; unmapped words are refused with slverr
    if (wr_fire) begin
      nx.aw_have = 1'b0;
      nx.w_have  = 1'b0;
      nx.bvalid  = 1'b1;
      nx.bresp   = wr_map ? dcc_pkg::RESP_OKAY : dcc_pkg::RESP_SLVERR;
    end else if (r.bvalid && S_AXI_BREADY) begin
      nx.bvalid = 1'b0;
    end
    nx.awready = !nx.aw_have;
    nx.wready  = !nx.w_have;
    // read: one outstanding, data snapshot at acceptance
    if (S_AXI_ARVALID && r.arready) begin
      nx.rvalid = 1'b1;
      nx.rdata  = 32'h0000_0000;
      nx.rresp  = dcc_pkg::RESP_SLVERR;
      for (int i = 0; i < NUM_CH; i++) begin
        if (rd_map && rd_idx == (AW-2)'(i)) begin
          nx.rdata = ctrl_word(r, i);
          nx.rresp = dcc_pkg::RESP_OKAY;
        end
      end
    end else if (r.rvalid && S_AXI_RREADY) begin
      nx.rvalid = 1'b0;
    end
    nx.arready = !nx.rvalid;
    // per-channel control
    for (int i = 0; i < NUM_CH; i++) begin
      wr_ch[i]  = wr_fire && wr_map && (wr_idx == (AW-2)'(i));
      // completion of the chosen neighbour, only when chaining is allowed
      chain[i]  = r.permit[i] && (r.dir[i] ? done_up[i] : done_dn[i]);
      // events while off are dropped unless the channel asks to keep them
      accept[i] = (CH_START_EVT[i] || CH_ABORT_EVT[i]) && (r.on[i] || r.ewo[i]);
      // software wins, then chaining, then end-of-block disable
      if (wr_ch[i] && r.wstrb[0]) begin
        nx.on[i] = r.wdata[dcc_pkg::ON_BIT];
      end else if (chain[i]) begin
        nx.on[i] = 1'b1;
      end else if (CH_BLOCK_DONE[i] && !r.auto_re[i]) begin
        nx.on[i] = 1'b0;
      end
      if (wr_ch[i] && r.wstrb[0]) begin
        nx.ewo[i]     = r.wdata[dcc_pkg::EWO_BIT];
        nx.permit[i]  = r.wdata[dcc_pkg::PERMIT_BIT];
        nx.auto_re[i] = r.wdata[dcc_pkg::AUTO_BIT];
        nx.pri[i*2 +: 2] = r.wdata[dcc_pkg::PRI_LSB +: dcc_pkg::PRI_W];
      end
      // byte 1 holds only the direction; busy is read only
      if (wr_ch[i] && r.wstrb[1]) begin
        nx.dir[i] = r.wdata[dcc_pkg::DIR_BIT];
      end
      // a new event beats the end-of-block clear in the same cycle
      if (accept[i]) begin
        nx.seen[i] = 1'b1;
      end else if (CH_BLOCK_DONE[i]) begin
        nx.seen[i] = 1'b0;
      end
      nx.abort[i] = CH_ABORT_EVT[i] && accept[i];
      // busy holds through the tail of a suspended transaction
      nx.busy[i]  = nx.on[i] || CH_XFER_ACTIVE[i];
      nx.run[i]   = nx.on[i] && nx.seen[i];
    end
    nx.grant  = arb_gnt;
    nx.gvalid = |arb_gnt;
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      r <= '0;
    end else begin
      r <= nx;
    end
  end

  // outputs come straight from the state register
  assign S_AXI_AWREADY  = r.awready;
  assign S_AXI_WREADY   = r.wready;
  assign S_AXI_BRESP    = r.bresp;
  assign S_AXI_BVALID   = r.bvalid;
  assign S_AXI_ARREADY  = r.arready;
  assign S_AXI_RDATA    = r.rdata;
  assign S_AXI_RRESP    = r.rresp;
  assign S_AXI_RVALID   = r.rvalid;
  assign CH_ENABLE      = r.on;
  assign CH_RUN         = r.run;
  assign CH_ABORT       = r.abort;
  assign CH_GRANT       = r.grant;
  assign CH_GRANT_VALID = r.gvalid;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RESETN);

  property p_rd_zero;
    S_AXI_RVALID |-> (S_AXI_RDATA[31:16] == 16'h0000);
  endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("upper half read nonzero");

  property p_rd_gap;
    S_AXI_RVALID |-> (S_AXI_RDATA[14:9] == 6'h00) && !S_AXI_RDATA[3];
  endproperty
  a_rd_gap: assert property (p_rd_gap) else $error("unused middle bits read nonzero");

  for (genvar i = 0; i < NUM_CH; i++) begin : g_chk
    property p_busy;
      r.on[i] |-> r.busy[i];
    endproperty
    a_busy: assert property (p_busy) else $error("enabled channel not busy");

    property p_tail;
      CH_XFER_ACTIVE[i] |=> r.busy[i] [*1];
    endproperty
    a_tail: assert property (p_tail) else $error("busy dropped during transaction");

    property p_sw_on;
      (wr_ch[i] && r.wstrb[0]) |=> (r.on[i] == $past(r.wdata[dcc_pkg::ON_BIT]));
    endproperty
    a_sw_on: assert property (p_sw_on) else $error("enable write not applied");

    property p_chain;
      (!(wr_ch[i] && r.wstrb[0]) && r.permit[i] && (r.dir[i] ? done_up[i] : done_dn[i])) |=> r.on[i];
    endproperty
    a_chain: assert property (p_chain) else $error("neighbour completion did not chain");

    property p_no_chain;
      (!r.on[i] && !r.permit[i] && !wr_ch[i]) |=> !r.on[i];
    endproperty
    a_no_chain: assert property (p_no_chain) else $error("channel enabled without permit");

    property p_auto;
      (CH_BLOCK_DONE[i] && !wr_ch[i] && !chain[i]) |=> (r.on[i] == ($past(r.on[i]) && $past(r.auto_re[i])));
    endproperty
    a_auto: assert property (p_auto) else $error("block end enable wrong");

    property p_drop;
      (CH_START_EVT[i] && !r.on[i] && !r.ewo[i] && !r.seen[i]) |=> !r.seen[i];
    endproperty
    a_drop: assert property (p_drop) else $error("event kept while off");

    property p_seen;
      (CH_START_EVT[i] && (r.on[i] || r.ewo[i])) |=> r.seen[i] ##1 (r.seen[i] || $past(CH_BLOCK_DONE[i]));
    endproperty
    a_seen: assert property (p_seen) else $error("event not flagged");
  end
endmodule // dcc_top

// >>> bench/dcc_engine_model.sv
// dcc_engine_model: behavioural stand-in for the transfer engine and request sources.
// assumes the bench calls its tasks from one process; outputs change just after clk rises.
`timescale 1ns/1ns
module dcc_engine_model #(
  parameter int NUM_CH = 4,  // channel count of the block under test
  parameter int TAIL   = 12  // cycles a transaction runs on after its channel is switched off
) (
  input  wire logic              clk,         // system clock
  input  wire logic [NUM_CH-1:0] enable,      // channel_on of each channel
  output logic      [NUM_CH-1:0] start_evt,   // start event pulses
  output logic      [NUM_CH-1:0] abort_evt,   // abort event pulses
  output logic      [NUM_CH-1:0] block_done,  // block complete pulses
  output logic      [NUM_CH-1:0] xfer_active, // transaction in flight
  output logic      [NUM_CH-1:0] req          // request pending
);
  logic [NUM_CH-1:0] engaged;     // channels that have work queued
  int                tail[NUM_CH]; // cycles left in the current transaction

  // ---------------------------------------------------------------
  // idle levels at time zero
  // ---------------------------------------------------------------
  initial begin
    start_evt   = '0;
    abort_evt   = '0;
    block_done  = '0;
    req         = '0;
    engaged     = '0;
  end

  // ---------------------------------------------------------------
  // a transaction never stops at once: it runs out its tail first
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    for (int i = 0; i < NUM_CH; i++) begin
      if (enable[i]) begin
        tail[i] <= TAIL;
      end else if (tail[i] != 0) begin
        tail[i] <= tail[i] - 1;
      end
      xfer_active[i] <= engaged[i] & (enable[i] | (tail[i] != 0));
    end
  end

  // one-cycle pulse; kind 0 start, 1 abort, else block done
  task automatic pulse(input int kind, input logic [NUM_CH-1:0] mask);
    @(posedge clk);
    case (kind)
      0: start_evt <= mask;
      1: abort_evt <= mask;
      default: block_done <= mask;
    endcase
    @(posedge clk);
    start_evt  <= '0;
    abort_evt  <= '0;
    block_done <= '0;
  endtask

  // request and work levels, held until changed
  task automatic set_levels(input logic [NUM_CH-1:0] r, input logic [NUM_CH-1:0] w);
    @(posedge clk);
    req     <= r;
    engaged <= w;
  endtask
endmodule // dcc_engine_model

// >>> bench/dma_channel_control_tb.sv
// dma_channel_control_tb: self-checking bench of dcc_top over AXI4-Lite.
// assumes four channels, channel i control word at byte 4*i, engine model alongside.
`timescale 1ns/1ns
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin mismatches++; \
  $display("BAD %0t got %h exp %h", $time, got, exp); end end
module dma_channel_control_tb;
  typedef struct packed {
    logic [7:0] wa; logic [31:0] wd; logic [3:0] ws; logic [1:0] br;
    logic [7:0] ra; logic [31:0] rd; logic [1:0] rr;
  } dcc_row_s; // one write, then one read back
  logic        clk, rst_n, awvalid, wvalid, bready, arvalid, rready;  // master side
  logic        awready, wready, bvalid, arready, rvalid, gv;          // slave side
  logic [7:0]  awaddr, araddr;                                        // byte addresses
  logic [31:0] wdata, rdata, rd;                                      // words; rd is last read
  logic [3:0]  wstrb;                                                 // byte strobes
  logic [1:0]  bresp, rresp, rs, br;                                  // response codes
  logic [3:0]  st, ab, dn, act, req, en, run, abo, gnt;               // channel lines
  int          mismatches, n_checks;                                  // verdict counters
  // ordinary cases: full write, partial strobes, unmapped, unaligned
  dcc_row_s rows[7] = '{
    '{8'h00, 32'hffff_ffff, 4'hf, 2'h0, 8'h00, 32'h0000_81f3, 2'h0},
    '{8'h04, 32'h0000_0141, 4'hf, 2'h0, 8'h04, 32'h0000_0141, 2'h0},
    '{8'h08, 32'h0000_01ff, 4'h1, 2'h0, 8'h08, 32'h0000_80f3, 2'h0},
    '{8'h0c, 32'h0000_0100, 4'h2, 2'h0, 8'h0c, 32'h0000_0100, 2'h0},
    '{8'h10, 32'h0000_0080, 4'hf, 2'h2, 8'h10, 32'h0000_0000, 2'h2},
    '{8'h01, 32'h0000_0000, 4'hf, 2'h2, 8'h00, 32'h0000_81f3, 2'h0},
    '{8'h00, 32'h0000_0000, 4'hf, 2'h0, 8'h00, 32'h0000_0000, 2'h0}};
  // chaining cases on channel 1: control word, done lines, expected enable
  logic [31:0] cw[6] = '{32'h120, 32'h120, 32'h020, 32'h020, 32'h100, 32'h000};
  logic [3:0]  cm[6] = '{4'b0100, 4'b0001, 4'b0001, 4'b0100, 4'b0100, 4'b0001};
  logic        ce[6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};

  dcc_top dut_u (.REF_CLK(clk), .RESETN(rst_n), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
    .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .CH_START_EVT(st),
    .CH_ABORT_EVT(ab), .CH_BLOCK_DONE(dn), .CH_XFER_ACTIVE(act), .CH_REQ(req), .CH_ENABLE(en),
    .CH_RUN(run), .CH_ABORT(abo), .CH_GRANT(gnt), .CH_GRANT_VALID(gv));
  dcc_engine_model mdl (.clk(clk), .enable(en), .start_evt(st), .abort_evt(ab),
    .block_done(dn), .xfer_active(act), .req(req));

  // ---------------------------------------------------------------
  // clock, time-zero levels, watchdog
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk); // tests need well under a tenth of this
    mismatches++;
    $display("BAD %0t watchdog", $time);
    report_and_stop();
  end

  // ---------------------------------------------------------------
  // bus tasks: hold each channel until its ready is seen at an edge
  // ---------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
    bit done;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    done = 0;
    r = 2'h3;
    for (int n = 0; n < 40 && !done; n++) begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        r = bresp;
        bready <= 1'b0;
        done = 1;
      end
    end
    if (!done) `CHK(1'b0, 1'b1)
  endtask
  task automatic rdw(input logic [7:0] a);
    bit done;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    done = 0;
    for (int n = 0; n < 40 && !done; n++) begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        rd = rdata;
        rs = rresp;
        rready <= 1'b0;
        done = 1;
      end
    end
    if (!done) `CHK(1'b0, 1'b1)
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    // one process owns every master-side line, time-zero levels included
    {rst_n, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata, wstrb} = '0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      rdw(8'(4 * i));
      `CHK(rd, dcc_pkg::CTRL_RST)
    end
    foreach (rows[k]) begin
      wr(rows[k].wa, rows[k].wd, rows[k].ws, br);
      `CHK(br, rows[k].br)
      rdw(rows[k].ra);
      `CHK(rd, rows[k].rd)
      `CHK(rs, rows[k].rr)
    end
    $display("table done");
    // each channel takes every priority code in turn; the top code wins
    mdl.set_levels(4'hf, 4'h0);
    for (int k = 0; k < 4; k++) begin
      for (int i = 0; i < 4; i++) wr(8'(4 * i), 32'h80 | 32'((i + k) % 4), 4'hf, br);
      repeat (2) @(posedge clk);
      #1 `CHK(gnt, 4'(1 << ((7 - k) % 4)))
      `CHK(gv, 1'b1)
    end
    // a switched-off channel never wins, even at the top level
    wr(8'h00, 32'h3, 4'hf, br);
    repeat (2) @(posedge clk);
    #1 `CHK(gnt, 4'b1000)
    // equal levels: the lower index keeps the grant
    wr(8'h0c, 32'h81, 4'hf, br);
    repeat (2) @(posedge clk);
    #1 `CHK(gnt, 4'b0100)
    mdl.set_levels(4'h0, 4'h0);
    repeat (2) @(posedge clk);
    #1 `CHK({gv, gnt}, 5'h0)
    for (int i = 0; i < 4; i++) wr(8'(4 * i), 32'h0, 4'hf, br);
    $display("grant done");
    // events on a switched-off channel are dropped unless kept
    mdl.pulse(0, 4'b0010);
    rdw(8'h04);
    `CHK(rd[2], 1'b0)
    mdl.pulse(1, 4'b0010);
    #1 `CHK(abo, 4'h0)
    wr(8'h04, 32'h40, 4'hf, br);
    mdl.pulse(1, 4'b0010);
    #1 `CHK(abo, 4'b0010)
    rdw(8'h04);
    `CHK(rd, 32'h0000_0044)
    $display("events done");
    // block done switches off unless auto re-enable is set
    wr(8'h04, 32'h80, 4'hf, br);
    `CHK({en[1], run[1]}, 2'b11)
    mdl.pulse(2, 4'b0010);
    #1 `CHK({en[1], run[1]}, 2'b00)
    wr(8'h04, 32'h90, 4'hf, br);
    mdl.pulse(0, 4'b0010);
    mdl.pulse(2, 4'b0010);
    #1 `CHK(en[1], 1'b1)
    rdw(8'h04);
    `CHK(rd, 32'h0000_8090)
    $display("auto done");
    foreach (cw[j]) begin
      wr(8'h04, cw[j], 4'hf, br);
      mdl.pulse(2, cm[j]);
      #1 `CHK(en[1], ce[j])
    end
    $display("chain done");
    // suspension waits for the transaction in flight
    mdl.set_levels(4'h0, 4'b0001);
    wr(8'h00, 32'h80, 4'hf, br);
    repeat (3) @(posedge clk);
    wr(8'h00, 32'h0, 4'hf, br);
    rdw(8'h00);
    `CHK(rd[15], 1'b1)
    for (int n = 0; n < 30 && rd[15]; n++) rdw(8'h00);
    `CHK(rd, 32'h0)
    mdl.set_levels(4'h0, 4'h0);
    $display("suspend done");
    // reset in mid-run clears every control word
    wr(8'h08, 32'h80, 4'hf, br);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    #1 `CHK({en, awready}, 5'h0)
    @(posedge clk);
    rst_n <= 1'b1;
    rdw(8'h08);
    `CHK(rd, dcc_pkg::CTRL_RST)
    $display("reset done");
    report_and_stop();
  end
endmodule // dma_channel_control_tb
